// File: rtl/frag_pkg.sv
// Shared constants and types of the fragment header checker
package frag_pkg;
	localparam int INFO_W     = 21;
	localparam int SLOTS      = 8;
	localparam int SLOT_W     = 3;
	localparam int ENTRY_W    = 26;
	localparam int FIFO_DEPTH = 32;
	localparam int MEM_AW     = 7;
	// First word field positions
	localparam int K_LSB      = 0;
	localparam int K_W        = 12;
	localparam int C_BIT      = 12;
	localparam int F_LSB      = 13;
	localparam int N_LSB      = 15;
	localparam int N_W        = 6;
	// Second word of an initial fragment
	localparam int R_BIT      = 0;
	localparam int M_BIT      = 1;
	localparam logic [1:0] FRAG_FIRST = 2'h3;
	localparam logic [7:0] REGION_WORDS = 8'h80;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS  = 12'h000;
	localparam logic [11:0] STAT_OFS  = 12'h004;
	localparam logic [11:0] EVT_OFS   = 12'h008;
	localparam logic [11:0] LEN_OFS   = 12'h00c;
	localparam logic [2:0]  NORM_PAGE = 3'h1;
	localparam logic [2:0]  MAIL_PAGE = 3'h2;
	// Control fields and reset value
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_FLUSH   = 1;
	localparam int CTRL_MAX_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_3f01;
	localparam logic [31:0] CTRL_MASK = 32'h0000_3f01;
	// Sticky event bits
	localparam int EV_W    = 5;
	localparam int EV_DONE = 0;
	localparam int EV_CKER = 1;
	localparam int EV_MISS = 2;
	localparam int EV_DISC = 3;
	localparam int EV_OVF  = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SEL_CTRL, SEL_STAT, SEL_EVT, SEL_LEN, SEL_NORM, SEL_MAIL, SEL_NONE
	} reg_sel_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CTRL, ST_BODY} proc_state_t;
endpackage

// File: rtl/word_stream_if.sv
// Valid/ready word stream between the checker and its FIFO
`timescale 1ns/1ns
`default_nettype none
interface word_stream_if #(parameter int W = 26);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: rtl/frag_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module frag_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 32
) (
	input  wire logic     clk_sys,
	input  wire logic     reset_n,
	word_stream_if.snk    s,
	word_stream_if.src    m
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    wp_d;
	logic [AW-1:0]    rp_q;
	logic [AW-1:0]    rp_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             rdy_q;
	logic             rdy_d;
	logic             push;
	logic             pop;

	// Ready is registered so the source sees a clean full indication
	assign s.ready = rdy_q;
	assign m.valid = (cnt_q != '0);
	assign m.data  = mem_q[rp_q];
	assign push    = s.valid & rdy_q;
	assign pop     = m.valid & m.ready;

	// Pointer and fill count update
	always_comb begin
		wp_d  = push ? wp_q + 1'b1 : wp_q;
		rp_d  = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		rdy_d = (cnt_d != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end

	// Storage needs no reset; only counted entries are ever read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wp_q] <= s.data;
		end
	end
endmodule
`default_nettype wire

// File: rtl/frag_check.sv
// Fragment header checker: check sum, reassembly and numbering
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Check sum field counts as zero
// - Sum covers every word of fragment
// - Word split into 8, 8, 5 bit addends
// - Sum, invert, keep low twelve bits
// - Continued flag keeps reassembly open
// - Fragment numbers 11 then 00,01,10 cycling
// - Cleared continued flag closes the message
// - Rollover limit comes from a register
// - Number gap flags missed messages
// - Retrieval flag enables per-address sequencing
// - No retrieval flag: no missed tracking
// - Only matching fragments are appended
// - Mail drop overwrites dedicated region
// - First word carries sum, flags, numbers
module frag_check (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        cw_valid,
	output logic             cw_ready,
	input  wire logic [20:0] cw_info,
	input  wire logic        cw_first,
	input  wire logic        cw_last,
	input  wire logic [2:0]  cw_slot,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// Three addends of one information word, low bit first
	function automatic logic [11:0] addends(input logic [20:0] w);
		addends = 12'(w[7:0]) + 12'(w[15:8]) + 12'(w[20:16]);
	endfunction

	// Fragment numbers skip 11 after the initial one
	function automatic logic [1:0] next_frag(input logic [1:0] f);
		next_frag = (f == 2'h2 || f == 2'h3) ? 2'h0 : f + 2'h1;
	endfunction

	// Shared address decode for reads and writes
	function automatic frag_pkg::reg_sel_t decode(input logic [11:0] a);
		if (a[11:9] == frag_pkg::NORM_PAGE)
			decode = frag_pkg::SEL_NORM;
		else if (a[11:9] == frag_pkg::MAIL_PAGE)
			decode = frag_pkg::SEL_MAIL;
		else if (a == frag_pkg::CTRL_OFS)
			decode = frag_pkg::SEL_CTRL;
		else if (a == frag_pkg::STAT_OFS)
			decode = frag_pkg::SEL_STAT;
		else if (a == frag_pkg::EVT_OFS)
			decode = frag_pkg::SEL_EVT;
		else if (a == frag_pkg::LEN_OFS)
			decode = frag_pkg::SEL_LEN;
		else
			decode = frag_pkg::SEL_NONE;
	endfunction

	word_stream_if #(.W(frag_pkg::ENTRY_W)) in_if ();
	word_stream_if #(.W(frag_pkg::ENTRY_W)) out_if ();

	// Input stream is buffered so bursts ride out a disabled checker
	assign in_if.valid = cw_valid;
	assign in_if.data  = {cw_first, cw_last, cw_slot, cw_info};
	assign cw_ready    = in_if.ready;

	frag_fifo #(
		.WIDTH (frag_pkg::ENTRY_W),
		.DEPTH (frag_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.s       (in_if.snk),
		.m       (out_if.src)
	);

	logic                 e_first;
	logic                 e_last;
	logic [2:0]           e_slot;
	logic [20:0]          info;
	logic                 pop;
	logic [31:0]          ctrl_q;
	logic [31:0]          ctrl_d;
	logic [5:0]           roll_max;
	logic                 flush;
	frag_pkg::proc_state_t st_q;
	frag_pkg::proc_state_t st_d;
	logic [11:0]          sum_q;
	logic [11:0]          sum_d;
	logic [11:0]          k_q;
	logic [11:0]          k_d;
	logic                 c_q;
	logic                 c_d;
	logic [1:0]           f_q;
	logic [1:0]           f_d;
	logic [5:0]           n_q;
	logic [5:0]           n_d;
	logic [2:0]           slot_q;
	logic [2:0]           slot_d;
	logic                 disc_q;
	logic                 disc_d;
	logic                 act_q;
	logic                 act_d;
	logic [2:0]           aslot_q;
	logic [2:0]           aslot_d;
	logic [5:0]           anum_q;
	logic [5:0]           anum_d;
	logic [1:0]           expf_q;
	logic [1:0]           expf_d;
	logic                 r_q;
	logic                 r_d;
	logic                 m_q;
	logic                 m_d;
	logic [7:0]           len_q [2];
	logic [7:0]           len_d [2];
	logic [7:0]           seen_q;
	logic [7:0]           seen_d;
	logic [5:0]           last_q [8];
	logic [5:0]           last_d [8];
	logic                 ck_q;
	logic                 ck_d;
	logic                 fin_q;
	logic                 fin_d;
	logic                 miss_q;
	logic                 miss_d;
	logic [5:0]           mcnt_q;
	logic [5:0]           mcnt_d;
	logic [4:0]           ev_set;
	logic                 mem_we;
	logic [7:0]           mem_wa;
	logic [20:0]          buf_q [256];
	logic [11:0]          cur_k;
	logic                 cur_c;
	logic [1:0]           cur_f;
	logic                 cur_disc;
	logic [5:0]           exp_n;
	logic [6:0]           span;

	assign {e_first, e_last, e_slot, info} = out_if.data;
	// Stall the drain while disabled so back-pressure reaches the source
	assign out_if.ready = ctrl_q[frag_pkg::CTRL_EN_BIT];
	assign pop          = out_if.valid & ctrl_q[frag_pkg::CTRL_EN_BIT];
	assign roll_max     = ctrl_q[frag_pkg::CTRL_MAX_LSB +: 6];

	// Word processing: check sum, header fields, reassembly, numbering
	always_comb begin
		st_d = st_q;     sum_d = sum_q;   k_d = k_q;       c_d = c_q;
		f_d = f_q;       n_d = n_q;       slot_d = slot_q; disc_d = disc_q;
		act_d = act_q;   aslot_d = aslot_q; anum_d = anum_q;
		expf_d = expf_q; r_d = r_q;       m_d = m_q;       len_d = len_q;
		seen_d = seen_q; last_d = last_q; ck_d = ck_q;     fin_d = fin_q;
		miss_d = miss_q; mcnt_d = mcnt_q; ev_set = '0;
		mem_we = 1'b0;   mem_wa = '0;
		cur_k = k_q;     cur_c = c_q;     cur_f = f_q;     cur_disc = disc_q;
		exp_n = '0;      span = 7'(roll_max) + 7'h1;
		if (pop) begin
			// Every word adds in; the sum field itself is masked out
			sum_d = (e_first ? 12'h000 : sum_q)
				+ addends(e_first ? {info[20:12], 12'h000} : info);
			if (e_first) begin
				// Header word of every fragment
				cur_k  = info[frag_pkg::K_LSB +: frag_pkg::K_W];
				cur_c  = info[frag_pkg::C_BIT];
				cur_f  = info[frag_pkg::F_LSB +: 2];
				k_d    = cur_k;
				c_d    = cur_c;
				f_d    = cur_f;
				n_d    = info[frag_pkg::N_LSB +: frag_pkg::N_W];
				slot_d = e_slot;
				if (cur_f == frag_pkg::FRAG_FIRST) begin
					cur_disc = 1'b0;
					st_d     = frag_pkg::ST_CTRL;
				end else begin
					// Continuation joins only the open message it matches
					cur_disc = !(act_q && e_slot == aslot_q
						&& n_d == anum_q && cur_f == expf_q);
					ev_set[frag_pkg::EV_DISC] = cur_disc;
					st_d = frag_pkg::ST_BODY;
				end
				disc_d = cur_disc;
			end else begin
				case (st_q)
					frag_pkg::ST_CTRL: begin
						// Second word of an initial fragment opens a message
						r_d     = info[frag_pkg::R_BIT];
						m_d     = info[frag_pkg::M_BIT];
						act_d   = 1'b1;
						aslot_d = slot_q;
						anum_d  = n_q;
						len_d[m_d] = 8'h00;
						if (r_d) begin
							// Next number wraps at the programmed limit
							exp_n = (last_q[slot_q] == roll_max) ? 6'h00
								: last_q[slot_q] + 6'h1;
							// A repeat number is a header plus data pair
							if (seen_q[slot_q] && n_q != last_q[slot_q]
								&& n_q != exp_n) begin
								miss_d = 1'b1;
								mcnt_d = (n_q >= exp_n) ? n_q - exp_n
									: 6'(7'(n_q) + span - 7'(exp_n));
								ev_set[frag_pkg::EV_MISS] = 1'b1;
							end else begin
								miss_d = 1'b0;
								mcnt_d = 6'h00;
							end
							seen_d[slot_q] = 1'b1;
							last_d[slot_q] = n_q;
						end
						st_d = frag_pkg::ST_BODY;
					end
					frag_pkg::ST_BODY: begin
						// Region holds more than one frame's worth of words
						if (!disc_q) begin
							if (len_q[m_q] < frag_pkg::REGION_WORDS) begin
								mem_we     = 1'b1;
								mem_wa     = {m_q, len_q[m_q][6:0]};
								len_d[m_q] = len_q[m_q] + 8'h1;
							end else begin
								ev_set[frag_pkg::EV_OVF] = 1'b1;
							end
						end
					end
					default: begin
						st_d = frag_pkg::ST_IDLE;
					end
				endcase
			end
			if (e_last) begin
				// Close the fragment and compare its check sum
				ck_d  = (~sum_d) != cur_k;
				fin_d = !cur_c;
				ev_set[frag_pkg::EV_DONE] = 1'b1;
				ev_set[frag_pkg::EV_CKER] = ck_d;
				if (!cur_disc) begin
					if (!cur_c)
						act_d = 1'b0;
					else
						expf_d = next_frag(cur_f);
				end
				st_d = frag_pkg::ST_IDLE;
			end
		end
		if (flush) begin
			act_d  = 1'b0;
			seen_d = '0;
		end
	end

	// Word processing state; cleared only by reset, flush acts above

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= frag_pkg::ST_IDLE;
			sum_q <= '0; k_q <= '0; c_q <= 1'b0; f_q <= '0; n_q <= '0;
			slot_q <= '0; disc_q <= 1'b0; act_q <= 1'b0; aslot_q <= '0;
			anum_q <= '0; expf_q <= '0; r_q <= 1'b0; m_q <= 1'b0;
			len_q <= '{default: '0};
			seen_q <= '0;
			last_q <= '{default: '0};
			ck_q <= 1'b0; fin_q <= 1'b0; miss_q <= 1'b0; mcnt_q <= '0;
		end else begin
			st_q <= st_d;
			sum_q <= sum_d; k_q <= k_d; c_q <= c_d; f_q <= f_d; n_q <= n_d;
			slot_q <= slot_d; disc_q <= disc_d; act_q <= act_d;
			aslot_q <= aslot_d; anum_q <= anum_d; expf_q <= expf_d;
			r_q <= r_d; m_q <= m_d; len_q <= len_d; seen_q <= seen_d;
			last_q <= last_d; ck_q <= ck_d; fin_q <= fin_d;
			miss_q <= miss_d; mcnt_q <= mcnt_d;
		end
	end

	// Message storage: normal region then mail drop region
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			buf_q[mem_wa] <= info;
		end
	end

	logic        aw_have_q;
	logic        aw_have_d;
	logic [11:0] awaddr_q;
	logic [11:0] awaddr_d;
	logic        w_have_q;
	logic        w_have_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic [3:0]  wstrb_q;
	logic [3:0]  wstrb_d;
	logic        awready_q;
	logic        awready_d;
	logic        wready_q;
	logic        wready_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        arready_q;
	logic        arready_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic [4:0]  evt_q;
	logic [4:0]  evt_d;
	logic        wr_fire;
	frag_pkg::reg_sel_t wsel;
	frag_pkg::reg_sel_t rsel;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign wsel    = decode(awaddr_q);
	assign rsel    = decode(s_axi_araddr);
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign flush   = wr_fire && wsel == frag_pkg::SEL_CTRL
		&& wstrb_q[0] && wdata_q[frag_pkg::CTRL_FLUSH];

	// Bus slave: address and data latch independently, one write at a time
	always_comb begin
		aw_have_d = aw_have_q; awaddr_d = awaddr_q;
		w_have_d = w_have_q;   wdata_d = wdata_q; wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;   bresp_d = bresp_q; ctrl_d = ctrl_q;
		arready_d = arready_q; rvalid_d = rvalid_q;
		rdata_d = rdata_q;     rresp_d = rresp_q;
		// A new event in the clearing cycle stays set
		evt_d = evt_q | ev_set;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = frag_pkg::RESP_OKAY;
			case (wsel)
				frag_pkg::SEL_CTRL: begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_q[b])
							ctrl_d[8*b +: 8] = wdata_q[8*b +: 8];
					end
					ctrl_d = ctrl_d & frag_pkg::CTRL_MASK;
				end
				frag_pkg::SEL_EVT: begin
					if (wstrb_q[0])
						evt_d = (evt_q & ~wdata_q[4:0]) | ev_set;
				end
				frag_pkg::SEL_STAT, frag_pkg::SEL_LEN: begin
					bresp_d = frag_pkg::RESP_OKAY;
				end
				default: begin
					bresp_d = frag_pkg::RESP_SLVERR;
				end
			endcase
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = ~aw_have_d & ~bvalid_d;
		wready_d  = ~w_have_d & ~bvalid_d;
		// Read answers one cycle after the address is taken
		if (s_axi_arvalid && arready_q) begin
			rvalid_d  = 1'b1;
			rresp_d   = frag_pkg::RESP_OKAY;
			case (rsel)
				frag_pkg::SEL_CTRL: rdata_d = ctrl_q;
				frag_pkg::SEL_STAT: rdata_d = {7'h00, slot_q, mcnt_q, 2'h0,
					n_q, f_q, r_q, m_q, miss_q, fin_q, ck_q, act_q};
				frag_pkg::SEL_EVT:  rdata_d = {27'h000_0000, evt_q};
				frag_pkg::SEL_LEN:  rdata_d = {16'h0000, len_q[1], len_q[0]};
				frag_pkg::SEL_NORM, frag_pkg::SEL_MAIL:
					rdata_d = {11'h000, buf_q[{rsel == frag_pkg::SEL_MAIL,
						s_axi_araddr[8:2]}]};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = frag_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
		end
		// Address is refused while read data stands
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0; awaddr_q <= '0; w_have_q <= 1'b0;
			wdata_q <= '0; wstrb_q <= '0; awready_q <= 1'b0;
			wready_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= '0;
			arready_q <= 1'b0; rvalid_q <= 1'b0; rdata_q <= '0;
			rresp_q <= '0; evt_q <= '0; ctrl_q <= frag_pkg::CTRL_RST;
		end else begin
			aw_have_q <= aw_have_d; awaddr_q <= awaddr_d;
			w_have_q <= w_have_d; wdata_q <= wdata_d; wstrb_q <= wstrb_d;
			awready_q <= awready_d; wready_q <= wready_d;
			bvalid_q <= bvalid_d; bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
			evt_q <= evt_d; ctrl_q <= ctrl_d;
		end
	end
endmodule
`default_nettype wire

// File: verification/frag_check_assertions.sv
// Bus handshake checks for the fragment header checker
`timescale 1ns/1ns
`default_nettype none
module frag_check_sva (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Steps of a transfer: request taken, then answer offered
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_give;
		s_axi_rvalid;
	endsequence
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	write_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	write_reopen_a: assert property (s_axi_bvalid && s_axi_bready |->
		##[1:2] (s_axi_awready && s_axi_wready)) else $error("write not reopened");
	read_answer_a: assert property (ar_take |=> r_give)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rdata moved");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during data");
	unmapped_read_a: assert property (ar_take ##0 (s_axi_araddr == 12'h100) |=>
		r_give ##0 (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000))
		else $error("unmapped read not refused");
	bresp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'h0)
		else $error("illegal write response");
endmodule
bind frag_check frag_check_sva i_sva (.*);
`default_nettype wire

// File: verification/word_source.sv
// Code word source standing in for the channel demodulator
`timescale 1ns/1ns
`default_nettype none
module word_source (
	input  wire logic   clk_sys,
	input  wire logic   reset_n,
	input  wire logic   slow,
	input  wire logic   cw_ready,
	output logic        cw_valid,
	output logic [20:0] cw_info,
	output logic        cw_first,
	output logic        cw_last,
	output logic [2:0]  cw_slot
);
	// Slot, last, first, word; fragments kept within 40 words
	logic [25:0] q[$];
	logic        gap_q;
	int          taken;
	// Hold a word until taken; idle info lines toggle so no stale value passes
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{cw_valid, cw_info, cw_first, cw_last, cw_slot} <= '0;
			gap_q <= 1'h0;
			taken <= 0;
		end else if (!cw_valid || cw_ready) begin
			taken <= taken + int'(cw_valid);
			gap_q <= slow && !gap_q;
			if (q.size() != 0 && !(slow && !gap_q)) begin
				{cw_slot, cw_last, cw_first, cw_info} <= q.pop_front();
				cw_valid <= 1'h1;
			end else begin
				cw_valid <= 1'h0;
				cw_info  <= ~cw_info;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the fragment header checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk_sys = 1'h0, reset_n = 1'h0, slow = 1'h0;
	logic        cw_valid, cw_ready, cw_first, cw_last;
	logic [20:0] cw_info;
	logic [2:0]  cw_slot;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          mismatches = 0, tests_run = 0, seed = 4, max_n = 63;
	int          last_n[8], known[8], nlen, mlen, open_n = -1, open_s, exp_f;
	int          cur_m;
	always #50 clk_sys = ~clk_sys;
	frag_check i_dut (.*);
	word_source i_src (.*);
	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One clock with a bounded budget; an exhausted budget ends the run
	task automatic tick(inout int n);
		@(posedge clk_sys);
		n--;
		if (n == 0) begin
			mismatches++;
			print_verdict();
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		int n = 200;
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [11:0] a);
		int n = 200;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				{rd, resp} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask
	// Send one fragment, then compare events, lengths and status with the model
	task automatic frag(input int s, c, f, n, r, m, nd, bad, hold);
		logic [20:0] w[$];
		int          sum = 0, disc, gap = 0, k = 400, t0;
		t0 = i_src.taken;
		w.push_back({n[5:0], f[1:0], c[0], 12'h000});
		if (f == 3) w.push_back({19'($random(seed)), m[0], r[0]});
		repeat (nd) w.push_back(21'($random(seed)));
		// Field as zero, 8/8/5 bit addends, inverted low twelve bits
		foreach (w[i]) sum += w[i][7:0] + w[i][15:8] + w[i][20:16];
		w[0][11:0] = 12'(~sum) ^ 12'(bad);
		foreach (w[i]) i_src.q.push_back({3'(s), i == w.size() - 1, i == 0, w[i]});
		if (hold) begin
			repeat (60) @(posedge clk_sys);
			check("fifo_taken", i_src.taken - t0, 32);
			axi_wr(frag_pkg::CTRL_OFS, frag_pkg::CTRL_RST);
		end
		while (i_src.q.size() != 0 || cw_valid) tick(k);
		// A stalled buffer may still hold 32 words after the source is done
		repeat (40) @(posedge clk_sys);
		disc = (f != 3) && !(open_n == n && open_s == s && exp_f == f);
		if (f == 3) begin
			if (r && known[s] && n != last_n[s])
				gap = (n - last_n[s] + max_n) % (max_n + 1);
			if (r) begin
				known[s] = 1;
				last_n[s] = n;
			end
			if (m) mlen = nd;
			else nlen = nd;
			open_n = c ? n : -1;
			open_s = s;
			exp_f = 0;
			cur_m = m;
		end else if (!disc) begin
			if (cur_m) mlen += nd;
			else nlen += nd;
			if (!c) open_n = -1;
			exp_f = (f + 1) % 3;
		end
		axi_rd(frag_pkg::EVT_OFS);
		check("event", rd & (disc ? 32'he : 32'h1f), {disc[0], gap != 0, bad[0], !disc});
		axi_wr(frag_pkg::EVT_OFS, 32'h0000_001f);
		axi_rd(frag_pkg::EVT_OFS);
		check("event_clear", rd, 0);
		axi_rd(frag_pkg::LEN_OFS);
		check("length", rd, {mlen[7:0], nlen[7:0]});
		axi_rd(frag_pkg::STAT_OFS);
		if (!disc) check("status", rd[2:1], {c == 0, bad[0]});
		if (f == 3) check("missed", rd[21:16], gap);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'h1;
		repeat (2) @(posedge clk_sys);
		axi_rd(frag_pkg::CTRL_OFS);
		check("ctrl_reset", rd, frag_pkg::CTRL_RST);
		axi_rd(12'h100);
		check("unmapped", rd, 32'h0000_0000);
		check("unmapped_resp", resp, frag_pkg::RESP_SLVERR);
		axi_wr(12'h200, 32'h0000_0000);
		check("region_write", resp, frag_pkg::RESP_SLVERR);
		// Every slot once, mail on odd slots, one bad check sum
		for (int i = 0; i < 8; i++) frag(i, 0, 3, i, 1, i & 1, i + 1, i == 5, 0);
		// Numbers per address: a gap, a repeat, no retrieval flag, then the next one
		frag(2, 0, 3, 6, 1, 0, 2, 0, 0);
		frag(2, 0, 3, 6, 1, 1, 3, 0, 0);
		frag(2, 0, 3, 20, 0, 0, 1, 0, 0);
		frag(2, 0, 3, 7, 1, 0, 1, 0, 0);
		// Rollover limit from the control register
		axi_wr(frag_pkg::CTRL_OFS, 32'h0000_0301);
		max_n = 3;
		frag(3, 0, 3, 0, 1, 0, 1, 0, 0);
		frag(3, 0, 3, 2, 1, 0, 1, 0, 0);
		axi_rd(frag_pkg::CTRL_OFS);
		check("ctrl_max", rd, 32'h0000_0301);
		axi_wr(frag_pkg::CTRL_OFS, frag_pkg::CTRL_RST);
		max_n = 63;
		// Continuations: stray number, slot and order, then 00,01,10,00
		frag(4, 1, 3, 9, 1, 0, 2, 0, 0);
		frag(4, 1, 0, 10, 0, 0, 1, 0, 0);
		frag(5, 1, 0, 9, 0, 0, 1, 0, 0);
		frag(4, 1, 1, 9, 0, 0, 1, 0, 0);
		for (int i = 0; i < 4; i++) frag(4, i < 3, i % 3, 9, 0, 0, 2, i == 3, 0);
		frag(4, 0, 1, 9, 0, 0, 1, 0, 0);
		// Flush forgets numbering
		axi_wr(frag_pkg::CTRL_OFS, frag_pkg::CTRL_RST | 32'h0000_0002);
		known = '{default: 0};
		frag(4, 0, 3, 30, 1, 0, 1, 0, 0);
		// Random traffic from a slow source
		slow <= 1'h1;
		repeat (6) frag($random(seed) & 7, 0, 3, $random(seed) & 63, 1,
			$random(seed) & 1, $random(seed) & 3, $random(seed) & 1, 0);
		slow <= 1'h0;
		// Buffer fills while draining is stalled, then drains
		axi_wr(frag_pkg::CTRL_OFS, 32'h0000_3f00);
		frag(6, 0, 3, 40, 1, 0, 38, 0, 1);
		print_verdict();
	end
endmodule
`default_nettype wire
